/* File: rtl/dcs_device.sv */
// Purpose: dma control and status register of the dma engine
// Assumes: host side and accesses 16 or 32 bits
// Notes: one-cycle access, ack in the cycle after req
//
// Implementation choice: register access over APB.
`default_nettype none
module dcs_device
  import dcs_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, low
  dcs_if.dev bus, // register port
  input wire logic rx_dma_start, // rx dma of a new frame begins
  input wire logic rx_dma_finish, // rx dma of a frame completes
  input wire logic rx_done_ack, // rx done interrupt acknowledged
  input wire logic tx_dma_finish, // tx dma operation completes
  input wire logic tx_done_ack, // tx done interrupt acknowledged
  input wire logic tx_dma_busy, // tx dma operation in progress
  input wire logic completer_abort_in, // target abort seen as master
  input wire logic initiator_abort_in, // master abort suffered
  input wire logic chip_reset, // global or host reset bit pulse
  output logic rx_dma_done, // rx done, same as status bit
  output logic tx_dma_done, // tx done, same as status bit
  output logic rx_poll_request, // rx poll pulse: reset timer, fetch
  output logic tx_poll_request, // tx poll pulse: reset timer, fetch
  output logic invalidate_write_off, // no invalidate write command
  output logic tx_status_update_en, // write back then poll done flag
  output logic [2:0] tx_fragment_batch, // effective batch, 1..5
  output logic dma_halt // halt tx and rx dma
);
  logic [31:0] ctl; // writable control bits, assembled
  logic tx_active;
  logic completer_abort_flag;
  logic initiator_abort_flag;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [31:0] status_word;
  logic [2:0] raw_batch;
  logic wr_hit;
  logic rd_hit; // read taken this cycle
  logic lo_wr; // write to the low half
  logic hi_wr; // write to the high half
  logic must_one; // bit 16 as last written
  logic inv_off_q; // invalidate write disable
  logic stat_off_q; // status update disable
  logic [2:0] batch_q; // batch field as written

  // a request is taken on the edge where it stands without an answer
  assign wr_hit = bus.req && bus.wr && !ack_q;
  assign rd_hit = bus.req && !bus.wr && !ack_q;
  // 16-bit halves selected by the byte lane pair enables
  assign lo_wr = wr_hit && bus.be[0];
  assign hi_wr = wr_hit && bus.be[1];

  // done flags: set by finish, cleared by acknowledge; rx done also by start
  dcs_sticky u_rx_done (
    .pclk(pclk),
    .presetn(presetn),
    .set(rx_dma_finish),
    .clr(rx_dma_start || rx_done_ack),
    .q(rx_dma_done)
  );
  dcs_sticky u_tx_done (
    .pclk(pclk),
    .presetn(presetn),
    .set(tx_dma_finish),
    .clr(tx_done_ack),
    .q(tx_dma_done)
  );

  // fatal abort flags, only chip reset clears them
  dcs_sticky u_cabort (
    .pclk(pclk),
    .presetn(presetn),
    .set(completer_abort_in),
    .clr(chip_reset),
    .q(completer_abort_flag)
  );
  dcs_sticky u_iabort (
    .pclk(pclk),
    .presetn(presetn),
    .set(initiator_abort_in),
    .clr(chip_reset),
    .q(initiator_abort_flag)
  );

  // bit 16 has no function; it is kept so that it reads back as written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      must_one <= DCS_RESET[DCS_MUST_ONE_BIT];
    end else if (hi_wr) begin
      must_one <= bus.wdata[DCS_MUST_ONE_BIT];
    end
  end

  // invalidate write disable, high half only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inv_off_q <= DCS_RESET[DCS_INV_OFF_BIT];
    end else if (hi_wr) begin
      inv_off_q <= bus.wdata[DCS_INV_OFF_BIT];
    end
  end

  // status update disable, high half only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_off_q <= DCS_RESET[DCS_STAT_OFF_BIT];
    end else if (hi_wr) begin
      stat_off_q <= bus.wdata[DCS_STAT_OFF_BIT];
    end
  end

  // fragment batch as written; bad values are mapped where it is used
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      batch_q <= DCS_RESET[DCS_BATCH_HI:DCS_BATCH_LO];
    end else if (hi_wr) begin
      batch_q <= bus.wdata[DCS_BATCH_HI:DCS_BATCH_LO];
    end
  end

  // writable bits in their register places, every other bit zero
  always_comb begin
    ctl = 32'h0000_0000;
    ctl[DCS_MUST_ONE_BIT] = must_one;
    ctl[DCS_INV_OFF_BIT] = inv_off_q;
    ctl[DCS_STAT_OFF_BIT] = stat_off_q;
    ctl[DCS_BATCH_HI:DCS_BATCH_LO] = batch_q;
  end

  // rx poll: one-cycle pulse, the bit itself never stores
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_poll_request <= 1'b0;
    end else begin
      rx_poll_request <= lo_wr && bus.wdata[DCS_RX_POLL_BIT];
    end
  end

  // tx poll: one-cycle pulse, the bit itself never stores
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_poll_request <= 1'b0;
    end else begin
      tx_poll_request <= lo_wr && bus.wdata[DCS_TX_POLL_BIT];
    end
  end

  // tx active follows the dma engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_active <= 1'b0;
    end else begin
      tx_active <= tx_dma_busy;
    end
  end

  // control outputs
  assign invalidate_write_off = ctl[DCS_INV_OFF_BIT];
  assign tx_status_update_en = !ctl[DCS_STAT_OFF_BIT];
  assign raw_batch = ctl[DCS_BATCH_HI:DCS_BATCH_LO];
  assign tx_fragment_batch = (raw_batch >= DCS_BATCH_MIN && raw_batch <= DCS_BATCH_MAX)
                             ? raw_batch : DCS_BATCH_MIN;
  assign dma_halt = completer_abort_flag || initiator_abort_flag;

  // read view: poll bits read as zero, reserved as zero
  always_comb begin
    status_word = ctl;
    status_word[DCS_RX_DONE_BIT] = rx_dma_done;
    status_word[DCS_TX_DONE_BIT] = tx_dma_done;
    status_word[DCS_TX_ACTIVE_BIT] = tx_active;
    status_word[DCS_CABORT_BIT] = completer_abort_flag;
    status_word[DCS_IABORT_BIT] = initiator_abort_flag;
  end

  // one-cycle answer, dropped for a cycle between accesses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus.req && !ack_q;
    end
  end

  // read data captured on the taken edge, held until the next read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= DCS_RESET;
    end else if (rd_hit) begin
      rdata_q <= status_word;
    end
  end

  assign bus.ack = ack_q;
  assign bus.rdata = rdata_q;
endmodule : dcs_device
`default_nettype wire

/* File: rtl/dcs_pkg.sv */
// Purpose: shared constants for the dma control and status register
// Assumes: one 32-bit register at offset 0, 50 MHz pclk
// Notes: field positions and reset value used by both ends
`default_nettype none
package dcs_pkg;
  localparam logic [7:0] DCS_OFFSET = 8'h00;
  localparam logic [31:0] DCS_RESET = 32'h0000_0000;
  localparam int DCS_RX_DONE_BIT = 3;
  localparam int DCS_RX_POLL_BIT = 4;
  localparam int DCS_TX_DONE_BIT = 11;
  localparam int DCS_TX_POLL_BIT = 12;
  localparam int DCS_TX_ACTIVE_BIT = 15;
  localparam int DCS_MUST_ONE_BIT = 16;
  localparam int DCS_INV_OFF_BIT = 18;
  localparam int DCS_STAT_OFF_BIT = 19;
  localparam int DCS_BATCH_LO = 20;
  localparam int DCS_BATCH_HI = 22;
  localparam int DCS_CABORT_BIT = 30;
  localparam int DCS_IABORT_BIT = 31;
  localparam logic [2:0] DCS_BATCH_MIN = 3'h1;
  localparam logic [2:0] DCS_BATCH_MAX = 3'h5;
  // writable control bits: 16, 18, 19, 22..20
  localparam logic [31:0] DCS_RW_MASK = 32'h007D_0000;
  // controller register offsets on apb
  localparam logic [7:0] CTL_CMD_OFF = 8'h00;
  localparam logic [7:0] CTL_WDATA_OFF = 8'h04;
  localparam logic [7:0] CTL_RDATA_OFF = 8'h08;
  localparam logic [7:0] CTL_STAT_OFF = 8'h0C;
endpackage : dcs_pkg
`default_nettype wire

/* File: rtl/dcs_if.sv */
// Purpose: register port between host controller and device register
// Assumes: single clock, word or half-word access strobes
// Notes: be selects 16-bit halves; both halves means a 32-bit access
`default_nettype none
interface dcs_if;
  logic req;
  logic wr;
  logic [1:0] be;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic ack;
  modport dev (input req, input wr, input be, input wdata, output rdata, output ack);
  modport host (output req, output wr, output be, output wdata, input rdata, input ack);
endinterface : dcs_if
`default_nettype wire

/* File: rtl/dcs_sticky.sv */
// Purpose: one sticky flag, set by hardware and cleared by a pulse
// Assumes: synchronous set and clear inputs
// Notes: set wins over clear in the same cycle
`default_nettype none
module dcs_sticky (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, low
  input wire logic set, // set pulse
  input wire logic clr, // clear pulse
  output logic q // flag
);
  // set beats clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= 1'b0;
    end else if (set) begin
      q <= 1'b1;
    end else if (clr) begin
      q <= 1'b0;
    end
  end
endmodule : dcs_sticky
`default_nettype wire

/* File: rtl/dcs_host.sv */
// Purpose: host controller that reaches the dma register for software
// Assumes: software drives the controller over apb
// Notes: writes force bit 16 to one and reserved bits to zero
`default_nettype none
module dcs_host
  import dcs_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  dcs_if.host bus // register port
);
  typedef enum logic [1:0] {DCS_IDLE, DCS_WAIT} dcs_state_e;
  dcs_state_e state;
  logic [31:0] wdata_r;
  logic [31:0] rdata_r;
  logic [1:0] be_r;
  logic wr_r;
  logic done_r;
  logic req_r;
  logic go;
  logic known;

  assign known = paddr == CTL_CMD_OFF || paddr == CTL_WDATA_OFF ||
                 paddr == CTL_RDATA_OFF || paddr == CTL_STAT_OFF;
  // command: bit0 start, bit1 write, bits 3..2 half enables
  assign go = psel && penable && pwrite && paddr == CTL_CMD_OFF && state == DCS_IDLE;

  // software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdata_r <= DCS_RESET;
      be_r <= 2'h3;
      wr_r <= 1'b0;
    end else if (psel && penable && pwrite) begin
      if (paddr == CTL_WDATA_OFF) begin
        wdata_r <= pwdata;
      end else if (go) begin
        wr_r <= pwdata[1];
        be_r <= (pwdata[3:2] == 2'h0) ? 2'h3 : pwdata[3:2];
      end
    end
  end

  // access sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= DCS_IDLE;
      req_r <= 1'b0;
      done_r <= 1'b0;
      rdata_r <= DCS_RESET;
    end else begin
      case (state)
        DCS_IDLE: begin
          if (go && pwdata[0]) begin
            req_r <= 1'b1;
            done_r <= 1'b0;
            state <= DCS_WAIT;
          end
        end
        DCS_WAIT: begin
          if (bus.ack) begin
            req_r <= 1'b0;
            done_r <= 1'b1;
            if (!wr_r) begin
              rdata_r <= bus.rdata;
            end
            state <= DCS_IDLE;
          end
        end
        default: state <= DCS_IDLE;
      endcase
    end
  end

  assign bus.req = req_r;
  assign bus.wr = wr_r;
  assign bus.be = be_r;
  // bit 16 set, reserved and read-only bits zero on write
  assign bus.wdata = (wdata_r & (DCS_RW_MASK | (32'h0000_0001 << DCS_RX_POLL_BIT)
                     | (32'h0000_0001 << DCS_TX_POLL_BIT)))
                     | (32'h0000_0001 << DCS_MUST_ONE_BIT);

  // apb read mux, zero-wait answer
  always_comb begin
    if (paddr == CTL_WDATA_OFF) begin
      prdata = wdata_r;
    end else if (paddr == CTL_RDATA_OFF) begin
      prdata = rdata_r;
    end else if (paddr == CTL_STAT_OFF) begin
      prdata = {30'h0, done_r, state == DCS_WAIT};
    end else begin
      prdata = 32'h0000_0000;
    end
  end
  assign pready = 1'b1;
  assign pslverr = psel && penable && !known;
endmodule : dcs_host
`default_nettype wire

/* File: testbench/dcs_chk_sva.sv */
// Purpose: assertions on the register port and the device pins
// Assumes: one clock domain, presetn async low
// Notes: placed beside the interface, no bind
`default_nettype none
module dcs_chk (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, low
  input wire logic req, // host request
  input wire logic wr, // write
  input wire logic [1:0] be, // half enables
  input wire logic [31:0] wdata, // write data
  input wire logic ack, // device answer
  input wire logic rx_dma_start, // rx begins
  input wire logic rx_dma_finish, // rx ends
  input wire logic rx_done_ack, // rx acknowledge
  input wire logic tx_dma_finish, // tx ends
  input wire logic tx_done_ack, // tx acknowledge
  input wire logic completer_abort_in, // target abort
  input wire logic initiator_abort_in, // master abort
  input wire logic chip_reset, // flag clear
  input wire logic rx_dma_done, // rx flag
  input wire logic tx_dma_done, // tx flag
  input wire logic rx_poll_request, // rx poll pulse
  input wire logic tx_poll_request, // tx poll pulse
  input wire logic [2:0] tx_fragment_batch, // effective batch
  input wire logic dma_halt // dma stop
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // a request taken, and a poll write among them
  sequence taken_s;
    req && !ack;
  endsequence
  sequence rx_poll_s;
    req && !ack && wr && be[0] && wdata[4];
  endsequence
  sequence tx_poll_s;
    req && !ack && wr && be[0] && wdata[12];
  endsequence
  // a poll pulse stands for exactly one cycle
  sequence rx_pulse_s;
    rx_poll_request ##1 !rx_poll_request;
  endsequence
  sequence tx_pulse_s;
    tx_poll_request ##1 !tx_poll_request;
  endsequence
  // port handshake
  ack_answer_a: assert property (taken_s |=> ack)
    else $error("no ack after request");
  ack_single_a: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  // done flags
  rx_done_set_a: assert property (rx_dma_finish |=> rx_dma_done)
    else $error("rx done not set");
  rx_done_clr_a: assert property ((rx_dma_start || rx_done_ack) && !rx_dma_finish
    |=> !rx_dma_done)
    else $error("rx done not cleared");
  tx_done_set_a: assert property (tx_dma_finish |=> tx_dma_done)
    else $error("tx done not set");
  tx_done_clr_a: assert property (tx_done_ack && !tx_dma_finish |=> !tx_dma_done)
    else $error("tx done not cleared");
  // poll pulse, one cycle, self clearing
  rx_poll_pulse_a: assert property (rx_poll_s |=> rx_pulse_s)
    else $error("rx poll pulse wrong");
  tx_poll_pulse_a: assert property (tx_poll_s |=> tx_pulse_s)
    else $error("tx poll pulse wrong");
  // abort flags halt dma until chip reset; effective batch stays in 1..5
  halt_set_a: assert property (completer_abort_in || initiator_abort_in
    |=> dma_halt)
    else $error("halt not raised");
  halt_hold_a: assert property (dma_halt && !chip_reset |=> dma_halt)
    else $error("halt dropped without reset");
  batch_range_a: assert property (tx_fragment_batch inside {[1:5]})
    else $error("batch out of range");
endmodule : dcs_chk
`default_nettype wire

/* File: testbench/test_dma_control_status.sv */
// Purpose: self-checking bench, host and device joined by the interface
// Assumes: apb master on pclk, pulses driven one cycle
// Notes: register reached through host command, data and status registers
`default_nettype none
module test_dma_control_status
  import dcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, busy = 0, serr;
  logic [7:0] paddr = '0, ev = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, rx_done, tx_done, rxp, txp, inv_off, stat_en, halt;
  logic [2:0] batch;
  int n_errors = 0, samples_checked = 0, n_rxp = 0, n_txp = 0;
  int evs[10] = '{1, 0, 1, 2, 3, 4, 5, 6, 2, 7};
  int exps[10] = '{5, 0, 5, 0, 10, 0, 48, 112, 112, 0};
  dcs_if bus_if ();
  // clock and poll pulse counters
  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    n_rxp <= n_rxp + int'(rxp);
    n_txp <= n_txp + int'(txp);
  end
  dcs_host dcs_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus(bus_if.host));
  dcs_device dcs_device_inst (.pclk(pclk), .presetn(presetn), .bus(bus_if.dev),
    .rx_dma_start(ev[0]), .rx_dma_finish(ev[1]), .rx_done_ack(ev[2]), .tx_dma_finish(ev[3]),
    .tx_done_ack(ev[4]), .tx_dma_busy(busy), .completer_abort_in(ev[5]),
    .initiator_abort_in(ev[6]), .chip_reset(ev[7]), .rx_dma_done(rx_done),
    .tx_dma_done(tx_done), .rx_poll_request(rxp), .tx_poll_request(txp),
    .invalidate_write_off(inv_off), .tx_status_update_en(stat_en),
    .tx_fragment_batch(batch), .dma_halt(halt));
  dcs_chk dcs_chk_inst (.pclk(pclk), .presetn(presetn), .req(bus_if.req), .wr(bus_if.wr),
    .be(bus_if.be), .wdata(bus_if.wdata), .ack(bus_if.ack), .rx_dma_start(ev[0]),
    .rx_dma_finish(ev[1]), .rx_done_ack(ev[2]), .tx_dma_finish(ev[3]), .tx_done_ack(ev[4]),
    .completer_abort_in(ev[5]), .initiator_abort_in(ev[6]), .chip_reset(ev[7]),
    .rx_dma_done(rx_done), .tx_dma_done(tx_done), .rx_poll_request(rxp),
    .tx_poll_request(txp), .tx_fragment_batch(batch), .dma_halt(halt));
  // compare and count
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // verdict and end of run
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  // one apb transfer, released only after the ready edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      n_errors++;
      conclude();
    end
    @(posedge pclk);
  endtask : apb
  // register access through the host command, waits for done
  task automatic dev(input logic w, input logic [1:0] b, input logic [31:0] d);
    int k;
    k = 0;
    if (w) apb(CTL_WDATA_OFF, 1'b1, d);
    apb(CTL_CMD_OFF, 1'b1, {28'h0, b, w, 1'b1});
    do begin
      apb(CTL_STAT_OFF, 1'b0, 32'h0);
      k++;
    end while (rd[1:0] !== 2'b10 && k < 20);
    if (k >= 20) begin
      n_errors++;
      conclude();
    end
    if (!w) apb(CTL_RDATA_OFF, 1'b0, 32'h0);
  endtask : dev
  // one-cycle event pulse on a side-band input
  task automatic pulse(input int i);
    ev[i] <= 1'b1;
    @(posedge pclk);
    ev <= '0;
    @(posedge pclk);
  endtask : pulse
  // main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    dev(1'b0, 2'b11, 32'h0);
    chk("reset value", rd, DCS_RESET);
    dev(1'b1, 2'b11, 32'hFFBE_0000);
    apb(CTL_WDATA_OFF, 1'b0, 32'h0);
    chk("wdata readback", rd, 32'hFFBE_0000);
    dev(1'b0, 2'b11, 32'h0);
    chk("control readback", rd, 32'h003D_0000);
    chk("control pins", {27'h0, inv_off, stat_en, batch}, 32'h0000_0013);
    $display("test control done");
    for (int b = 0; b < 8; b++) begin
      dev(1'b1, 2'b11, 32'(b) << DCS_BATCH_LO);
      chk("batch", {29'h0, batch}, (b >= 1 && b <= 5) ? b : 1);
    end
    chk("update on", {31'h0, stat_en}, 32'h1);
    dev(1'b1, 2'b01, 32'h0004_0000);
    chk("low half only", {31'h0, inv_off}, 32'h0);
    dev(1'b1, 2'b10, 32'h0004_1010);
    chk("high half", {31'h0, inv_off}, 32'h1);
    $display("test batch done");
    dev(1'b1, 2'b01, 32'h0000_1010);
    dev(1'b0, 2'b11, 32'h0);
    chk("poll counts", {n_txp[15:0], n_rxp[15:0]}, 32'h0001_0001);
    chk("poll bits read", rd & 32'h0000_1010, 32'h0);
    $display("test poll done");
    for (int i = 0; i < 10; i++) begin
      pulse(evs[i]);
      dev(1'b1, 2'b11, 32'h0);
      dev(1'b0, 2'b11, 32'h0);
      chk("flags", {25'h0, rd[31:30], halt, rd[11], rd[3], tx_done, rx_done},
          exps[i]);
    end
    $display("test flags done");
    for (int v = 1; v >= 0; v--) begin
      busy <= v[0];
      dev(1'b0, 2'b11, 32'h0);
      chk("tx active", {31'h0, rd[15]}, v);
    end
    apb(8'h10, 1'b0, 32'h0);
    chk("unmapped", {31'h0, serr}, 32'h1);
    $display("test status done");
    conclude();
  end
endmodule : test_dma_control_status
`default_nettype wire
